//--- verilog/sar_ctrl_map.vh
// Register offsets, field positions, reset values and timing counts of the converter control
`ifndef SAR_CTRL_MAP_VH
`define SAR_CTRL_MAP_VH
`define OFF_CONTROL_0 4'h0
`define OFF_CONTROL_1 4'h1
`define OFF_CONFIG_2 4'h2
`define OFF_CONTROL_3 4'h3
`define OFF_CLOCK 4'h4
`define OFF_INPUT_SRC 4'h5
`define OFF_RES_LOW 4'h6
`define OFF_RES_HIGH 4'h7
`define OFF_ROUTE_SEL 4'h8
`define C0_SW_START 0
`define C0_EDGE_MODE 1
`define C0_FABRIC_TRIG 2
`define C0_DAC_CLEAR 3
`define C0_COHERENT 4
`define C1_DONE 0
`define C1_IRQ_EN 1
`define C1_IRQ_EDGE 2
`define C3_HALF_SUPPLY_EN 6
`define CLK_GATE 3
`define CLK_BYPASS 4
`define SRC_POS_FABRIC 4
`define SRC_NEG_FABRIC 3
`define RST_CONTROL_0 8'h00
`define RST_CONTROL_1 8'h00
`define RST_CONFIG_2 8'h03
`define RST_CONTROL_3 8'h00
`define RST_CLOCK 8'h00
`define RST_INPUT_SRC 8'h00
`define REF_HALF_SUPPLY 3'b010
`define REF_DAC 3'b011
`define REF_BANDGAP_1 3'b100
`define REF_BANDGAP_2 3'b101
`define REF_OFF_0 3'b000
`define REF_OFF_7 3'b111
`define CONV_FIXED_CYCLES 5'd14
`define SAMPLE_SHORT_MAX 6'd3
`endif

//--- verilog/sar_clock_select.v
// Converter clock selection, gating and output resynchronisation
`default_nettype none
module sar_clock_select (
  input wire aclk, // System clock
  input wire aresetn, // Synchronous reset, active low
  input wire [2:0] clk_sel, // Clock source selector
  input wire gate_en, // Clock gate enable
  input wire bypass, // Skip resynchronisation
  input wire [4:0] clk_ticks, // Four analog clock ticks and fabric tick
  input wire [11:0] raw_result, // Unaligned converter output
  input wire raw_done, // Unaligned end of conversion
  output reg conv_tick, // Selected converter clock tick
  output wire [11:0] aligned_result, // Result seen by the control logic
  output wire aligned_done // Done seen by the control logic
);
  reg [11:0] res_q;
  reg done_q;
  reg tick_sel;
  // Selector codes 0..3 analog clocks, 4 the fabric clock, rest off
  always @* begin
    case (clk_sel)
      3'd0, 3'd1, 3'd2, 3'd3, 3'd4: tick_sel = clk_ticks[clk_sel];
      default: tick_sel = 1'b0;
    endcase
    conv_tick = tick_sel & gate_en;
  end
  // Aligned copy; bypass trades a cycle of latency for skew risk
  always @(posedge aclk) begin
    if (!aresetn) begin
      res_q <= 12'h000;
      done_q <= 1'b0;
    end else begin
      res_q <= raw_result;
      done_q <= raw_done;
    end
  end
  assign aligned_result = bypass ? raw_result : res_q;
  assign aligned_done = bypass ? raw_done : done_q;
endmodule // sar_clock_select
`default_nettype wire

//--- verilog/sar_approx_core.v
// Successive approximation sequencer with sampling window and resolution
`default_nettype none
`include "sar_ctrl_map.vh"
module sar_approx_core (
  input wire aclk, // System clock
  input wire aresetn, // Synchronous reset, active low
  input wire tick, // Converter clock tick
  input wire start, // Begin a conversion
  input wire [5:0] sample_len, // Sample cycles minus one
  input wire [1:0] resolution, // 0:12 bits, 1:10 bits, 2:8 bits
  input wire dac_clear, // Clear DAC at sampling start
  input wire [11:0] analog_in, // Sampled analog value
  output reg busy, // Conversion in progress
  output reg [11:0] result, // Finished result
  output reg done // One-cycle end of conversion
);
  localparam ST_IDLE = 3'b001;
  localparam ST_SAMPLE = 3'b010;
  localparam ST_CONV = 3'b100;
  reg [2:0] state_q;
  reg [6:0] cnt_q;
  reg [11:0] dac_q;
  reg [11:0] held_q;
  reg [3:0] bit_q;
  wire [3:0] last_bit = (resolution == 2'd2) ? 4'd4 : (resolution == 2'd1) ? 4'd2 : 4'd0;
  // Trial keeps only decided bits, so a retained DAC cannot skew a compare
  wire [12:0] above_w = 13'h1FFF << (bit_q + 4'd1);
  wire [11:0] trial_w = (dac_q & above_w[11:0]) | (12'h001 << bit_q);
  // Sampling then one bit per tick, 14 fixed cycles beyond a short window
  always @(posedge aclk) begin
    if (!aresetn) begin
      state_q <= ST_IDLE;
      cnt_q <= 7'd0;
      dac_q <= 12'h000;
      held_q <= 12'h000;
      bit_q <= 4'd0;
      busy <= 1'b0;
      result <= 12'h000;
      done <= 1'b0;
    end else begin
      done <= 1'b0;
      case (state_q)
        ST_IDLE: begin
          if (start) begin
            state_q <= ST_SAMPLE;
            busy <= 1'b1;
            cnt_q <= {1'b0, (sample_len < `SAMPLE_SHORT_MAX) ? `SAMPLE_SHORT_MAX : sample_len} + 7'd1;
            if (dac_clear) begin
              dac_q <= 12'h000;
            end
          end
        end
        ST_SAMPLE: if (tick) begin
          held_q <= analog_in;
          if (cnt_q <= 7'd1) begin
            state_q <= ST_CONV;
            cnt_q <= {2'd0, `CONV_FIXED_CYCLES};
            bit_q <= 4'd11;
          end else begin
            cnt_q <= cnt_q - 7'd1;
          end
        end
        ST_CONV: if (tick) begin
          if (cnt_q > 7'd2 && bit_q >= last_bit) begin
            dac_q[bit_q] <= (held_q >= trial_w);
            bit_q <= bit_q - 4'd1;
          end
          if (cnt_q <= 7'd1) begin
            state_q <= ST_IDLE;
            busy <= 1'b0;
            done <= 1'b1;
            result <= dac_q & (12'hFFF << last_bit); // Bits below the resolution read zero
          end else begin
            cnt_q <= cnt_q - 7'd1;
          end
        end
        default: state_q <= ST_IDLE;
      endcase
    end
  end
endmodule // sar_approx_core
`default_nettype wire

//--- verilog/sar_adc_digital_control.v
// AXI4-Lite register file and conversion sequencing around the converter core
//
// Our own choices: the AXI4-Lite slave port and the address map.
`default_nettype none
`include "sar_ctrl_map.vh"
// Contract
// - Input-source bit 4 set lets the fabric pick the positive input.
// - Input-source bit 3 set lets the fabric pick the negative input.
// - Clock control bits 2:0 pick one analog clock or fabric clock.
// - Clock control bit 3 gates the selected converter clock.
// - Outputs are resynchronised unless clock control bit 4 bypasses it.
// - Config 2 bits 5:0 set sampling window of 1 to 64 cycles; the code runs windows below 4 as 4.
// - Control 0 bit 3 clears the DAC at each sampling start.
// - Conversion takes 18 cycles for short windows, 78 for 64.
// - Control 0 bits 7:6 select one of four power levels.
// - Control 1 bits 7:5 select reference mux input or tristate.
// - Control 0 bit 2 picks fabric or software bit 0 trigger.
// - Level mode converts back to back while request stays high.
// - Edge mode converts once and clears the request at completion.
// - Control 0 bit 1 picks level or edge request interpretation.
// - Fabric triggers add routing delay beyond 18 cycles.
// - Config 2 bits 7:6 set 8, 10 or 12 bit resolution.
// - Completion sets sticky done flag, cleared by reading result.
// - Result high bits 3:0 carry result bits 11:8.
// - Coherency holds new results until both result bytes are read.
// - Control 1 bit 1 enables done interrupt, bit 2 edge or level.
module sar_adc_digital_control #(
  parameter FABRIC_DELAY = 2 // Pipeline stages on fabric request; fabric done gets one stage more
) (
  input wire aclk, // System clock, 20 MHz
  input wire aresetn, // Synchronous reset, active low
  input wire [31:0] s_axi_awaddr, // Write address
  input wire s_axi_awvalid, // Write address valid
  output wire s_axi_awready, // Write address ready
  input wire [31:0] s_axi_wdata, // Write data
  input wire [3:0] s_axi_wstrb, // Write strobes
  input wire s_axi_wvalid, // Write data valid
  output wire s_axi_wready, // Write data ready
  output wire [1:0] s_axi_bresp, // Write response
  output wire s_axi_bvalid, // Write response valid
  input wire s_axi_bready, // Write response ready
  input wire [31:0] s_axi_araddr, // Read address
  input wire s_axi_arvalid, // Read address valid
  output wire s_axi_arready, // Read address ready
  output wire [31:0] s_axi_rdata, // Read data
  output wire [1:0] s_axi_rresp, // Read response
  output wire s_axi_rvalid, // Read data valid
  input wire s_axi_rready, // Read data ready
  input wire [4:0] clk_ticks, // Analog clock ticks 0..3, fabric tick 4
  input wire fabric_trigger, // Fabric conversion request
  input wire [3:0] fabric_pos_sel, // Fabric positive input choice
  input wire [3:0] fabric_neg_sel, // Fabric negative input choice
  input wire [11:0] analog_in, // Comparator-side sampled value
  output reg [3:0] pos_input_sel, // Positive input selection
  output reg [3:0] neg_input_sel, // Negative input selection
  output reg [1:0] power_level, // 0 full, 1 half, 2 third, 3 quarter
  output reg [2:0] ref_mux_sel, // Reference mux input
  output reg ref_mux_enable, // Reference mux drives its output
  output reg fabric_done, // End of conversion toward the fabric
  output reg conv_irq // End of conversion interrupt
);
  reg [7:0] ctrl0_q;
  reg [7:0] ctrl1_q;
  reg [7:0] cfg2_q;
  reg [7:0] ctrl3_q;
  reg [7:0] clk_q;
  reg [7:0] src_q;
  reg [7:0] route_q;
  reg [7:0] res_lo_q;
  reg [7:0] res_hi_q;
  reg done_flag_q;
  reg lo_read_q;
  reg hi_read_q;
  reg [FABRIC_DELAY-1:0] trig_pipe_q;
  reg [FABRIC_DELAY-1:0] done_pipe_q;
  reg edge_armed_q;
  reg irq_pulse_q;
  reg [31:0] awaddr_q;
  reg aw_held_q;
  reg [31:0] wdata_q;
  reg [3:0] wstrb_q;
  reg w_held_q;
  reg bvalid_q;
  reg rvalid_q;
  reg [31:0] rdata_q;
  reg start_req;
  wire conv_tick;
  wire core_busy;
  wire core_done;
  wire [11:0] core_result;
  wire [11:0] res_aligned;
  wire done_aligned;

  // Word index decode used by both address paths
  function [3:0] reg_index;
    input [31:0] addr;
    begin
      reg_index = addr[5:2];
    end
  endfunction

  // Only offsets 0..8 exist; everything else answers SLVERR
  function mapped;
    input [31:0] addr;
    begin
      mapped = (addr[31:6] == 26'd0) && (addr[5:2] <= `OFF_ROUTE_SEL);
    end
  endfunction

  wire do_write = aw_held_q && w_held_q && !bvalid_q;
  wire [3:0] w_idx = reg_index(awaddr_q);
  wire wr_en = do_write && wstrb_q[0] && mapped(awaddr_q);
  wire [7:0] wbyte = wdata_q[7:0];
  wire do_read = s_axi_arvalid && !rvalid_q;
  wire [3:0] r_idx = reg_index(s_axi_araddr);
  wire rd_lo = do_read && mapped(s_axi_araddr) && r_idx == `OFF_RES_LOW;
  wire rd_hi = do_read && mapped(s_axi_araddr) && r_idx == `OFF_RES_HIGH;
  reg [1:0] bresp_q;
  reg [1:0] rresp_q;

  // Channel acceptance; write address and data each held until the pair is complete
  assign s_axi_awready = !aw_held_q && !bvalid_q;
  assign s_axi_wready = !w_held_q && !bvalid_q;
  assign s_axi_arready = !rvalid_q;
  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rdata = rdata_q;
  assign s_axi_rresp = rresp_q;

  // Write channel capture and response
  always @(posedge aclk) begin
    if (!aresetn) begin
      awaddr_q <= 32'h0000_0000;
      aw_held_q <= 1'b0;
      wdata_q <= 32'h0000_0000;
      wstrb_q <= 4'h0;
      w_held_q <= 1'b0;
      bvalid_q <= 1'b0;
      bresp_q <= 2'b00;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        awaddr_q <= s_axi_awaddr;
        aw_held_q <= 1'b1;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        wdata_q <= s_axi_wdata;
        wstrb_q <= s_axi_wstrb;
        w_held_q <= 1'b1;
      end
      if (do_write) begin
        aw_held_q <= 1'b0;
        w_held_q <= 1'b0;
        bvalid_q <= 1'b1;
        bresp_q <= mapped(awaddr_q) ? 2'b00 : 2'b10;
      end else if (bvalid_q && s_axi_bready) begin
        bvalid_q <= 1'b0;
      end
    end
  end

  // Read data; result reads also clear done and feed coherency
  always @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_q <= 1'b0;
      rdata_q <= 32'h0000_0000;
      rresp_q <= 2'b00;
    end else if (do_read) begin
      rvalid_q <= 1'b1;
      rresp_q <= mapped(s_axi_araddr) ? 2'b00 : 2'b10;
      case (mapped(s_axi_araddr) ? r_idx : 4'hF) // Unmapped reads return zero
        `OFF_CONTROL_0: rdata_q <= {24'h00_0000, ctrl0_q};
        `OFF_CONTROL_1: rdata_q <= {24'h00_0000, ctrl1_q[7:1], done_flag_q};
        `OFF_CONFIG_2: rdata_q <= {24'h00_0000, cfg2_q};
        `OFF_CONTROL_3: rdata_q <= {24'h00_0000, ctrl3_q};
        `OFF_CLOCK: rdata_q <= {24'h00_0000, clk_q};
        `OFF_INPUT_SRC: rdata_q <= {24'h00_0000, src_q};
        `OFF_RES_LOW: rdata_q <= {24'h00_0000, res_lo_q};
        `OFF_RES_HIGH: rdata_q <= {24'h00_0000, res_hi_q};
        `OFF_ROUTE_SEL: rdata_q <= {24'h00_0000, route_q};
        default: rdata_q <= 32'h0000_0000;
      endcase
    end else if (rvalid_q && s_axi_rready) begin
      rvalid_q <= 1'b0;
    end
  end

  // Software-written configuration registers
  always @(posedge aclk) begin
    if (!aresetn) begin
      ctrl1_q <= `RST_CONTROL_1;
      cfg2_q <= `RST_CONFIG_2;
      ctrl3_q <= `RST_CONTROL_3;
      clk_q <= `RST_CLOCK;
      src_q <= `RST_INPUT_SRC;
      route_q <= 8'h00;
    end else if (wr_en) begin
      case (w_idx)
        `OFF_CONTROL_1: ctrl1_q <= {wbyte[7:1], 1'b0};
        `OFF_CONFIG_2: cfg2_q <= wbyte;
        `OFF_CONTROL_3: ctrl3_q <= wbyte;
        `OFF_CLOCK: clk_q <= wbyte;
        `OFF_INPUT_SRC: src_q <= wbyte;
        `OFF_ROUTE_SEL: route_q <= wbyte;
        default: ctrl3_q <= ctrl3_q;
      endcase
    end
  end

  // Control 0; hardware clears the start bit at completion only in edge mode
  always @(posedge aclk) begin
    if (!aresetn) begin
      ctrl0_q <= `RST_CONTROL_0;
    end else if (wr_en && w_idx == `OFF_CONTROL_0) begin
      ctrl0_q <= wbyte; // Software raise wins over a same-cycle clear
    end else if (done_aligned && ctrl0_q[`C0_EDGE_MODE]) begin
      ctrl0_q[`C0_SW_START] <= 1'b0;
    end
  end

  // Input selection source, fabric or routing register
  always @* begin
    pos_input_sel = src_q[`SRC_POS_FABRIC] ? fabric_pos_sel : route_q[7:4];
    neg_input_sel = src_q[`SRC_NEG_FABRIC] ? fabric_neg_sel : route_q[3:0];
    power_level = ctrl0_q[7:6];
  end

  // Reference mux; half-supply needs the enable bit in control 3
  always @* begin
    ref_mux_sel = ctrl1_q[7:5];
    case (ctrl1_q[7:5])
      `REF_OFF_0, `REF_OFF_7: ref_mux_enable = 1'b0;
      `REF_HALF_SUPPLY: ref_mux_enable = ctrl3_q[`C3_HALF_SUPPLY_EN];
      default: ref_mux_enable = 1'b1;
    endcase
  end

  // Fabric request and done pass routing stages, lengthening the loop
  always @(posedge aclk) begin
    if (!aresetn) begin
      trig_pipe_q <= {FABRIC_DELAY{1'b0}};
      done_pipe_q <= {FABRIC_DELAY{1'b0}};
      fabric_done <= 1'b0;
    end else begin
      trig_pipe_q <= {trig_pipe_q[FABRIC_DELAY-2:0], fabric_trigger};
      done_pipe_q <= {done_pipe_q[FABRIC_DELAY-2:0], done_aligned};
      fabric_done <= done_pipe_q[FABRIC_DELAY-1];
    end
  end

  wire request = ctrl0_q[`C0_FABRIC_TRIG] ? trig_pipe_q[FABRIC_DELAY-1] : ctrl0_q[`C0_SW_START];

  // Level mode restarts while request holds; edge mode needs a fresh rise
  always @* begin
    if (ctrl0_q[`C0_EDGE_MODE]) begin
      start_req = request && edge_armed_q && !core_busy;
    end else begin
      start_req = request && !core_busy;
    end
  end

  always @(posedge aclk) begin
    if (!aresetn) begin
      edge_armed_q <= 1'b1;
    end else if (start_req) begin
      edge_armed_q <= 1'b0;
    end else if (!request) begin
      edge_armed_q <= 1'b1;
    end
  end

  // Result capture with read coherency and sticky done
  always @(posedge aclk) begin
    if (!aresetn) begin
      res_lo_q <= 8'h00;
      res_hi_q <= 8'h00;
      done_flag_q <= 1'b0;
      lo_read_q <= 1'b1;
      hi_read_q <= 1'b1;
    end else begin
      if (rd_lo) lo_read_q <= 1'b1;
      if (rd_hi) hi_read_q <= 1'b1;
      if (rd_lo || rd_hi) done_flag_q <= 1'b0;
      if (done_aligned) begin
        done_flag_q <= 1'b1;
        if (!ctrl0_q[`C0_COHERENT] || (lo_read_q && hi_read_q)) begin
          res_lo_q <= res_aligned[7:0];
          res_hi_q <= {4'h0, res_aligned[11:8]};
          lo_read_q <= 1'b0;
          hi_read_q <= 1'b0;
        end
      end
    end
  end

  // Interrupt as a pulse or the sticky level
  always @(posedge aclk) begin
    if (!aresetn) begin
      irq_pulse_q <= 1'b0;
      conv_irq <= 1'b0;
    end else begin
      irq_pulse_q <= done_aligned;
      if (!ctrl1_q[`C1_IRQ_EN]) begin
        conv_irq <= 1'b0;
      end else if (ctrl1_q[`C1_IRQ_EDGE]) begin
        conv_irq <= done_aligned && !irq_pulse_q;
      end else begin
        conv_irq <= done_flag_q || done_aligned;
      end
    end
  end

  sar_clock_select u_clock (
    .aclk(aclk),
    .aresetn(aresetn),
    .clk_sel(clk_q[2:0]),
    .gate_en(clk_q[`CLK_GATE]),
    .bypass(clk_q[`CLK_BYPASS]),
    .clk_ticks(clk_ticks),
    .raw_result(core_result),
    .raw_done(core_done),
    .conv_tick(conv_tick),
    .aligned_result(res_aligned),
    .aligned_done(done_aligned)
  );

  // Fixed 14 conversion ticks plus the window: 18 at four, 78 at 64
  sar_approx_core u_core (
    .aclk(aclk),
    .aresetn(aresetn),
    .tick(conv_tick),
    .start(start_req),
    .sample_len(cfg2_q[5:0]),
    .resolution(cfg2_q[7:6]),
    .dac_clear(ctrl0_q[`C0_DAC_CLEAR]),
    .analog_in(analog_in),
    .busy(core_busy),
    .result(core_result),
    .done(core_done)
  );
endmodule // sar_adc_digital_control
`default_nettype wire

//--- tb/fabric_model.sv
// Fabric partner: converter clock ticks, trigger request and input choices
`default_nettype none
module fabric_model (
  input wire logic aclk, // System clock
  input wire logic aresetn, // Sync reset, active low
  input wire logic trig_want, // Bench asks for a request level
  output logic [4:0] clk_ticks, // Source k ticks every 2^k cycles
  output logic fabric_trigger, // Request toward the converter
  output logic [3:0] fabric_pos_sel, // Positive input choice
  output logic [3:0] fabric_neg_sel // Negative input choice
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [3:0] cnt_q;
  // Analog clocks run free; request passes one routing stage
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cnt_q <= 4'h0;
      fabric_trigger <= 1'b0;
    end else begin
      cnt_q <= cnt_q + 4'h1;
      fabric_trigger <= trig_want;
    end
  end
  // Choices change every cycle, so a stale route cannot pass
  assign clk_ticks = {cnt_q == 4'h0, cnt_q[2:0] == 3'h0, cnt_q[1:0] == 2'h0, !cnt_q[0], 1'b1};
  assign fabric_pos_sel = cnt_q;
  assign fabric_neg_sel = ~cnt_q;
endmodule // fabric_model
`default_nettype wire

//--- tb/sar_adc_digital_control_sva.sv
// Port-level checker of the converter control block
`default_nettype none
module sar_ctrl_checker (
  input wire logic aclk, // Clock
  input wire logic aresetn, // Reset
  input wire logic [31:0] s_axi_awaddr, // AW addr
  input wire logic s_axi_awvalid, // AW valid
  input wire logic s_axi_awready, // AW ready
  input wire logic [31:0] s_axi_wdata, // W data
  input wire logic [3:0] s_axi_wstrb, // W strobes
  input wire logic s_axi_wvalid, // W valid
  input wire logic s_axi_wready, // W ready
  input wire logic s_axi_bvalid, // B valid
  input wire logic s_axi_bready, // B ready
  input wire logic [3:0] fabric_pos_sel, // Fabric pos
  input wire logic [3:0] fabric_neg_sel, // Fabric neg
  input wire logic [3:0] pos_input_sel, // Pos sel
  input wire logic [3:0] neg_input_sel, // Neg sel
  input wire logic [1:0] power_level, // Power
  input wire logic [2:0] ref_mux_sel, // Ref sel
  input wire logic ref_mux_enable, // Ref drive
  input wire logic fabric_done, // Done
  input wire logic conv_irq // Irq
);
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  logic pend_q;
  logic [7:0] c0_q, c1_q, src_q, rte_q;
  logic [5:0] gap_q;
  // Shadow registers; assumes address and data are offered together
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      {pend_q, c0_q, c1_q, src_q, rte_q, gap_q} <= '0;
    end else begin
      if (s_axi_wvalid && s_axi_wready && s_axi_wstrb[0]) begin
        case (s_axi_awaddr[7:0])
          8'h00: c0_q <= s_axi_wdata[7:0];
          8'h04: c1_q <= s_axi_wdata[7:0];
          8'h14: src_q <= s_axi_wdata[7:0];
          8'h20: rte_q <= s_axi_wdata[7:0];
          default: ;
        endcase
      end
      pend_q <= (s_axi_awvalid && s_axi_awready) || (pend_q && !(s_axi_bvalid && s_axi_bready));
      gap_q <= fabric_done ? 6'h00 : (gap_q == 6'h3F ? gap_q : gap_q + 6'h01);
    end
  end
  AST_POS_SEL: assert property (!pend_q |->
    pos_input_sel == (src_q[4] ? fabric_pos_sel : rte_q[7:4])) else $error("positive selection wrong");
  AST_NEG_SEL: assert property (!pend_q |->
    neg_input_sel == (src_q[3] ? fabric_neg_sel : rte_q[3:0])) else $error("negative selection wrong");
  AST_POWER: assert property (!pend_q |-> power_level == c0_q[7:6])
    else $error("power level wrong");
  AST_REF_SEL: assert property (!pend_q |-> ref_mux_sel == c1_q[7:5])
    else $error("reference choice wrong");
  AST_REF_OFF: assert property (ref_mux_sel != 3'b010 |->
    ref_mux_enable == !(ref_mux_sel inside {3'b000, 3'b111})) else $error("reference tristate wrong");
  AST_IRQ_MASK: assert property (!pend_q && !c1_q[1] |-> !conv_irq)
    else $error("masked interrupt seen");
  AST_IRQ_PULSE: assert property (!pend_q && c1_q[2] && c1_q[1] && conv_irq |=> !conv_irq)
    else $error("edge interrupt too long");
  AST_DONE_GAP: assert property (fabric_done |-> gap_q >= 6'h11)
    else $error("conversions too close");
endmodule // sar_ctrl_checker
`default_nettype wire

//--- tb/sar_adc_digital_control_tb.sv
// Self-checking bench for the converter control block
`default_nettype none
module sar_adc_digital_control_tb;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int FD = 2;
  logic aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready, trig_want;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, fabric_trigger;
  logic fabric_done, conv_irq, ref_mux_enable;
  logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata, d;
  logic [3:0] s_axi_wstrb, fabric_pos_sel, fabric_neg_sel, pos_input_sel, neg_input_sel;
  logic [1:0] s_axi_bresp, s_axi_rresp, power_level, r;
  logic [2:0] ref_mux_sel;
  logic [4:0] clk_ticks;
  logic [11:0] analog_in;
  int num_errors, num_checks, n, t, p, k;
  // Address, data, readback, {power, reference, enable}
  logic [7:0] rows [14][4] = '{'{8'h00, 8'hC0, 8'hC0, 8'h30}, '{8'h04, 8'hFF, 8'hFE, 8'h3E},
    '{8'h04, 8'h45, 8'h44, 8'h34}, '{8'h0C, 8'h40, 8'h40, 8'h35}, '{8'h04, 8'h60, 8'h60, 8'h37},
    '{8'h00, 8'h40, 8'h40, 8'h17}, '{8'h04, 8'h80, 8'h80, 8'h19}, '{8'h00, 8'h80, 8'h80, 8'h29},
    '{8'h14, 8'h18, 8'h18, 8'h29}, '{8'h20, 8'hA5, 8'hA5, 8'h29}, '{8'h10, 8'h1F, 8'h1F, 8'h29},
    '{8'h04, 8'hA0, 8'hA0, 8'h2B}, '{8'h0C, 8'h00, 8'h00, 8'h2B}, '{8'h00, 8'h00, 8'h00, 8'h0B}};
  logic [7:0] rst_v [9] = '{8'h00, 8'h00, 8'h03, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
  // Clock select, config, analog value, expected result
  logic [15:0] cv [5][4] = '{'{16'h0008, 16'h0003, 16'h0A5F, 16'h0A5F}, '{16'h0019, 16'h007F, 16'h0A5F, 16'h0A5C},
    '{16'h000A, 16'h0081, 16'h0A5F, 16'h0A50}, '{16'h001B, 16'h0003, 16'h03C1, 16'h03C1},
    '{16'h000C, 16'h0047, 16'h03C1, 16'h03C0}};

  sar_adc_digital_control #(.FABRIC_DELAY(FD)) dut_u (.*);
  fabric_model fabric_u (.*);

  // 20 MHz clock
  initial begin
    aclk = 1'b0;
    forever #25 aclk = ~aclk;
  end

  task automatic chk(input string nm, input logic [31:0] seen, exp);
    num_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("unexpected %s: expected %h, seen %h", nm, exp, seen);
    end
  endtask

  // Change after an edge; each channel drops at the edge that takes it, response into r
  task automatic w(input logic [7:0] a, dt);
    logic aw, wd;
    @(posedge aclk);
    s_axi_awaddr <= {24'h00_0000, a};
    s_axi_wdata <= {24'h00_0000, dt};
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'b111;
    {aw, wd} = 2'b11;
    while (aw || wd) begin
      @(posedge aclk);
      aw = aw && !s_axi_awready;
      wd = wd && !s_axi_wready;
      s_axi_awvalid <= aw;
      s_axi_wvalid <= wd;
    end
    do @(posedge aclk); while (!s_axi_bvalid);
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask

  // Read data into d and response into r at the edge that takes rvalid
  task automatic rd(input logic [7:0] a);
    @(posedge aclk);
    s_axi_araddr <= {24'h00_0000, a};
    {s_axi_arvalid, s_axi_rready} <= 2'b11;
    do @(posedge aclk); while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    do @(posedge aclk); while (!s_axi_rvalid);
    {r, d} = {s_axi_rresp, s_axi_rdata};
    s_axi_rready <= 1'b0;
  endtask

  task automatic rc(input logic [7:0] a, input logic [31:0] exp, input string nm);
    rd(a);
    chk(nm, d, exp);
  endtask

  task automatic wait_done(input int lim, output int m);
    m = 0;
    while (fabric_done !== 1'b1 && m < lim) begin
      @(negedge aclk);
      m++;
    end
  endtask

  task automatic conv(input logic [7:0] ck, cf, c0, input logic [11:0] an, output int m);
    analog_in <= an;
    w(8'h10, ck);
    w(8'h08, cf);
    w(8'h00, c0);
    wait_done(3000, m);
  endtask

  task automatic give_verdict();
    $display("checks %0d, errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // Watchdog well beyond the expected run of some 5000 cycles
  initial begin
    repeat (40000) @(posedge aclk);
    num_errors++;
    give_verdict();
  end

  initial begin
    {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready, trig_want} = '0;
    {s_axi_awaddr, s_axi_wdata, s_axi_araddr} = '0;
    s_axi_wstrb = 4'hF;
    analog_in = 12'h000;
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    foreach (rst_v[i]) rc(8'(i * 4), {24'h0, rst_v[i]}, "reset value");
    foreach (rows[i]) begin
      w(rows[i][0], rows[i][1]);
      rc(rows[i][0], {24'h0, rows[i][2]}, "readback");
      chk("level outputs", {26'h0, power_level, ref_mux_sel, ref_mux_enable}, {24'h0, rows[i][3]});
    end
    w(8'h40, 8'hFF);
    chk("unmapped write resp", {30'h0, r}, 32'h2);
    rd(8'h40);
    chk("unmapped read", {r, d[29:0]}, 32'h8000_0000);
    // Software edge conversions over every clock source and resolution
    w(8'h04, 8'h02);
    foreach (cv[i]) begin
      conv(cv[i][0][7:0], cv[i][1][7:0], 8'h03, cv[i][2][11:0], n);
      p = 1 << cv[i][0][2:0];
      t = (cv[i][1][5:0] < 6'h03 ? 3 : int'(cv[i][1][5:0])) + 15;
      chk("conversion time", 32'(n >= t * p - p && n <= t * p + p + FD + 6), 32'h1);
      chk("level irq", {31'h0, conv_irq}, 32'h1);
      rc(8'h04, 32'h0000_0003, "done flag");
      rc(8'h00, 32'h0000_0002, "start auto clear");
      rc(8'h18, {24'h0, cv[i][3][7:0]}, "result low");
      rc(8'h1C, {28'h0, cv[i][3][11:8]}, "result high");
      rc(8'h04, 32'h0000_0002, "done cleared");
      chk("level irq cleared", {31'h0, conv_irq}, 32'h0);
    end
    // Coherency: a half-read result must not be overwritten
    w(8'h04, 8'h06);
    conv(8'h08, 8'h03, 8'h13, 12'h123, n);
    rc(8'h18, 32'h0000_0023, "first low");
    rc(8'h1C, 32'h0000_0001, "first high");
    conv(8'h08, 8'h03, 8'h13, 12'h456, n);
    rc(8'h18, 32'h0000_0056, "second low");
    conv(8'h08, 8'h03, 8'h13, 12'h789, n);
    rc(8'h1C, 32'h0000_0004, "held high");
    rc(8'h18, 32'h0000_0056, "held low");
    // Gate closed: nothing completes until it opens
    conv(8'h00, 8'h03, 8'h03, 12'h0F0, n);
    chk("gated clock idle", n, 3000);
    w(8'h10, 8'h08);
    wait_done(3000, n);
    chk("gate reopened", 32'(n < 3000), 32'h1);
    // Fabric level requests; software start bit must be ignored
    w(8'h00, 8'h05);
    wait_done(200, n);
    chk("software start ignored", n, 200);
    @(posedge aclk);
    trig_want <= 1'b1;
    wait_done(3000, n);
    chk("fabric latency", 32'(n > 18), 32'h1);
    k = 0;
    repeat (400) begin
      @(negedge aclk);
      k += int'(fabric_done === 1'b1);
    end
    chk("back to back", 32'(k >= 4 && k <= 23), 32'h1);
    @(posedge aclk);
    trig_want <= 1'b0;
    repeat (60) @(posedge aclk);
    wait_done(200, n);
    chk("stopped after drop", n, 200);
    give_verdict();
  end
endmodule // sar_adc_digital_control_tb

bind sar_adc_digital_control sar_ctrl_checker chk_u (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
  .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_bready,
  .fabric_pos_sel, .fabric_neg_sel, .pos_input_sel, .neg_input_sel, .power_level, .ref_mux_sel,
  .ref_mux_enable, .fabric_done, .conv_irq);
`default_nettype wire
